// file: eeaf_defs.svh
// eeaf_defs.svh: numeric constants of the eeprom address front end
`ifndef EEAF_DEFS_SVH
`define EEAF_DEFS_SVH

// ------------------------------------------------------------
// address byte layout
// ------------------------------------------------------------
`define EEAF_TYPE_ARRAY   4'hA
`define EEAF_TYPE_SECCFG  4'hB
`define EEAF_HOST_MFG     7'h7C
`define EEAF_HOST_HS      5'h01
`define EEAF_TYPE_MSB     7
`define EEAF_TYPE_LSB     4
`define EEAF_HW_MSB       3
`define EEAF_HW_LSB       1
`define EEAF_HOST_LSB     1
`define EEAF_HS_LSB       3
`define EEAF_RW_BIT       0
`define EEAF_BIT_LAST     3'h7

// ------------------------------------------------------------
// word address layout and array organisation
// ------------------------------------------------------------
`define EEAF_CFG_SEL_BIT  7
`define EEAF_B1_PG_MSB    6
`define EEAF_B2_PG_LSB    6
`define EEAF_OFF_MSB      5
`define EEAF_SN_MSB       6
`define EEAF_SN_LSB       4
`define EEAF_SN_ROW       3'h0
`define EEAF_PAGE_W       9
`define EEAF_OFF_W        6
`define EEAF_OFF_STEP     6'h01

// ------------------------------------------------------------
// words, identification, buffering
// ------------------------------------------------------------
`define EEAF_BYTE_W       8
`define EEAF_KIND_W       2
`define EEAF_WORD_W       10
`define EEAF_BUF_W        11
`define EEAF_BUF_DEPTH    2
`define EEAF_MFG_ID_W     24
`define EEAF_MFG_BYTES    2'h3

`endif

// file: eeaf_pkg.sv
// eeaf_pkg: state and word types of the eeprom address front end
`include "eeaf_defs.svh"
package eeaf_pkg;

  typedef enum logic [4:0] {
    LS_IDLE = 5'h01,
    LS_RX   = 5'h02,
    LS_ACK  = 5'h04,
    LS_TX   = 5'h08,
    LS_TACK = 5'h10
  } eeaf_lstate_t;

  typedef enum logic [`EEAF_KIND_W-1:0] {
    WK_DATA   = 2'h0,
    WK_ARRAY  = 2'h1,
    WK_SECCFG = 2'h2,
    WK_HOST   = 2'h3
  } eeaf_kind_t;

  typedef struct packed {
    eeaf_lstate_t               st;
    logic [2:0]                 bitcnt;
    logic [`EEAF_BYTE_W-1:0]    sh;
    logic                       first;
    logic                       ack;
    logic                       go_tx;
    logic                       data_ok;
    logic                       mfg_arm;
    logic                       mfg_sel;
    logic [`EEAF_MFG_ID_W-1:0]  tx_sh;
    logic [1:0]                 tx_left;
    logic                       start_clr;
    logic                       req_tgl;
    logic [`EEAF_WORD_W-1:0]    req_word;
    logic [1:0]                 ack_sync;
    logic [1:0]                 busy_sync;
    logic [1:0]                 rdy_sync;
    logic [2:0]                 hw_s1;
    logic [2:0]                 hw_s2;
  } eeaf_link_t;

  typedef struct packed {
    logic                       arst_n;
    logic                       busy;
    logic                       wp_s1;
    logic                       wp_s2;
    logic                       req_s1;
    logic                       req_s2;
    logic                       ack_tgl;
    eeaf_kind_t                 region;
    logic                       wr_dir;
    logic [1:0]                 idx;
    logic [`EEAF_BYTE_W-1:0]    b1;
    logic                       sn_area;
    logic [`EEAF_PAGE_W-1:0]    page;
    logic [`EEAF_OFF_W-1:0]     off;
  } eeaf_core_t;

endpackage

// file: eeaf_buf.sv
// eeaf_buf: small shift fifo whose head entry is a register
`timescale 1ns/1ps
`include "eeaf_defs.svh"
module eeaf_buf
  import eeaf_pkg::*;
#(
  parameter int W     = `EEAF_BUF_W,
  parameter int DEPTH = `EEAF_BUF_DEPTH
)(
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [CW-1:0]           cnt;
    logic                    vld;
  } eeaf_bstate_t;

  eeaf_bstate_t st_reg;
  eeaf_bstate_t st_next;
  logic         pop;
  logic         push;
  logic [CW-1:0] base;

  assign in_ready  = (st_reg.cnt != CW'(DEPTH));
  assign out_valid = st_reg.vld;
  assign out_data  = st_reg.mem[0];
  assign pop       = st_reg.vld & out_ready;
  assign push      = in_valid & in_ready;

  always_comb begin
    st_next = st_reg;
    base    = st_reg.cnt - CW'(pop);
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        st_next.mem[i] = st_reg.mem[i+1];
      end
    end
    if (push) begin
      st_next.mem[base] = in_data;
    end
    st_next.cnt = base + CW'(push);
    st_next.vld = (st_next.cnt != '0);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

// file: eeaf_front.sv
// eeaf_front: power-on gating, address byte decode and write-protect front end
`timescale 1ns/1ps
`include "eeaf_defs.svh"
// How it works
// - commands ignored while reset holds; standby entered once reset releases (threshold 1.5 V).
// - three hardware address pins must equal the address byte bits to select.
// - write-protect high blocks array and security writes; reads are unaffected.
// - data changes only with clock low; a falling data line while clock high marks start.
// - data line is open drain: pulled low or released, never driven high.
// - array is 512 pages of 64 bytes; offsets wrap inside the page.
// - read-only 24-bit manufacturer value returned by the host-code identification sequence.
// - first byte after start is type identifier, hardware address and direction bit.
// - reserved host codes are accepted to enter the alternative modes.
// - every valid address byte is acknowledged except silent host-code cases, during a write cycle and while a word handshake is pending.
// - locked configuration register rejects every later write.
// - serial number rows are read-only; user identification rows lock against writes.
// - lowest address bit one means read, zero means write.
// - mismatching address byte gets no acknowledge and device returns to standby.
// - no byte is acknowledged while an internal write cycle runs.
module eeaf_front
  import eeaf_pkg::*;
#(
  // arbitrary identification value
  parameter logic [`EEAF_MFG_ID_W-1:0] MFG_ID    = 24'h05A3C7,
  parameter int                        BUF_DEPTH = `EEAF_BUF_DEPTH
)(
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire logic                    scl,
  input  wire logic                    sda_i,
  output logic                         sda_o,
  output logic                         sda_oe,
  input  wire logic                    hw_addr_pin_bit0,
  input  wire logic                    hw_addr_pin_bit1,
  input  wire logic                    hw_addr_pin_bit2,
  input  wire logic                    wp,
  input  wire logic                    wr_busy,
  input  wire logic                    cfg_locked,
  input  wire logic                    sec_locked,
  output logic                         standby,
  output logic                         out_valid,
  input  wire logic                    out_ready,
  output logic [`EEAF_KIND_W-1:0]      out_kind,
  output logic                         out_wr_ok,
  output logic [`EEAF_BYTE_W-1:0]      out_byte,
  output logic [`EEAF_PAGE_W-1:0]      page,
  output logic [`EEAF_OFF_W-1:0]       page_off
);

  localparam eeaf_link_t LINK_RST = '{st: LS_IDLE, default: '0};
  localparam eeaf_core_t CORE_RST = '{region: WK_DATA, default: '0};

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic addr_hit(input logic [`EEAF_BYTE_W-1:0] b,
                                    input logic [3:0]              dtype,
                                    input logic [2:0]              hw);
    addr_hit = (b[`EEAF_TYPE_MSB:`EEAF_TYPE_LSB] == dtype) &&
               (b[`EEAF_HW_MSB:`EEAF_HW_LSB] == hw);
  endfunction

  eeaf_link_t              link_reg;
  eeaf_link_t              link_next;
  eeaf_core_t              core_reg;
  eeaf_core_t              core_next;
  logic                    start_pend_reg;
  logic                    start_arst_n;
  logic                    oe_reg;
  logic                    oe_next;
  logic                    zero_reg;
  logic [`EEAF_BYTE_W-1:0] byte_in;
  logic                    hs_free;
  logic                    ack_ok;
  logic                    new_word;
  logic                    buf_rdy;
  logic                    wr_ok;
  logic [`EEAF_BUF_W-1:0]  buf_in;
  logic [`EEAF_BUF_W-1:0]  buf_out;
  eeaf_kind_t              w_kind;
  logic [`EEAF_BYTE_W-1:0] w_byte;

  // ------------------------------------------------------------
  // start detector, clocked by the falling data line
  // ------------------------------------------------------------
  // the link logic clears it through start_clr right after the rising edge that sees it; bus timing keeps it
  // stable long before the first rising clock edge of the byte
  assign start_arst_n = core_reg.arst_n & ~link_reg.start_clr;

  always_ff @(negedge sda_i or negedge start_arst_n) begin
    if (!start_arst_n) begin
      start_pend_reg <= 1'b0;
    end else if (scl) begin
      start_pend_reg <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // link receive and transmit, rising clock edge
  // ------------------------------------------------------------
  assign byte_in = {link_reg.sh[`EEAF_BYTE_W-2:0], sda_i};
  assign hs_free = (link_reg.req_tgl == link_reg.ack_sync[1]);
  assign ack_ok  = link_reg.rdy_sync[1] & ~link_reg.busy_sync[1];

  always_comb begin
    logic       push;
    eeaf_kind_t kind;
    push      = 1'b0;
    kind      = WK_DATA;
    link_next = link_reg;
    link_next.rdy_sync  = {link_reg.rdy_sync[0], 1'b1};
    link_next.busy_sync = {link_reg.busy_sync[0], core_reg.busy};
    link_next.ack_sync  = {link_reg.ack_sync[0], core_reg.ack_tgl};
    link_next.hw_s1     = {hw_addr_pin_bit2, hw_addr_pin_bit1, hw_addr_pin_bit0};
    link_next.hw_s2     = link_reg.hw_s1;
    link_next.start_clr = start_pend_reg;
    if (!link_reg.rdy_sync[1]) begin
      link_next.st = LS_IDLE;
    end else if (start_pend_reg) begin
      link_next.st      = LS_RX;
      link_next.bitcnt  = 3'h1;
      link_next.sh      = {{(`EEAF_BYTE_W-1){1'b0}}, sda_i};
      link_next.first   = 1'b1;
      link_next.data_ok = 1'b0;
    end else begin
      unique case (link_reg.st)
        LS_IDLE: begin
        end
        LS_RX: begin
          link_next.sh     = byte_in;
          link_next.bitcnt = link_reg.bitcnt + 3'h1;
          if (link_reg.bitcnt == `EEAF_BIT_LAST) begin
            link_next.st    = LS_ACK;
            link_next.ack   = 1'b0;
            link_next.go_tx = 1'b0;
            link_next.first = 1'b0;
            if (link_reg.first) begin
              link_next.mfg_arm = 1'b0;
              if (byte_in[`EEAF_BYTE_W-1:`EEAF_HOST_LSB] == `EEAF_HOST_MFG) begin
                if (!byte_in[`EEAF_RW_BIT]) begin
                  link_next.mfg_arm = 1'b1;
                  link_next.mfg_sel = 1'b0;
                  link_next.ack     = ack_ok;
                end else if (link_reg.mfg_sel) begin
                  link_next.ack     = ack_ok;
                  link_next.go_tx   = 1'b1;
                  link_next.tx_sh   = MFG_ID;
                  link_next.tx_left = `EEAF_MFG_BYTES;
                end
              end else if (byte_in[`EEAF_BYTE_W-1:`EEAF_HS_LSB] == `EEAF_HOST_HS) begin
                // stays silent, but the mode entry is reported
                push = hs_free;
                kind = WK_HOST;
              end else if (addr_hit(byte_in, `EEAF_TYPE_ARRAY, link_reg.hw_s2) ||
                           addr_hit(byte_in, `EEAF_TYPE_SECCFG, link_reg.hw_s2)) begin
                link_next.ack     = ack_ok & hs_free;
                link_next.data_ok = ~byte_in[`EEAF_RW_BIT];
                link_next.mfg_sel = 1'b0;
                push = ack_ok & hs_free;
                kind = (byte_in[`EEAF_TYPE_LSB]) ? WK_SECCFG : WK_ARRAY;
              end
            end else if (link_reg.mfg_arm) begin
              link_next.mfg_arm = 1'b0;
              if (addr_hit(byte_in, `EEAF_TYPE_ARRAY, link_reg.hw_s2)) begin
                link_next.mfg_sel = 1'b1;
                link_next.ack     = ack_ok;
              end
            end else if (link_reg.data_ok) begin
              link_next.ack = ack_ok & hs_free;
              push = ack_ok & hs_free;
            end
          end
        end
        LS_ACK: begin
          link_next.bitcnt = 3'h0;
          if (!link_reg.ack) begin
            link_next.st = LS_IDLE;
          end else if (link_reg.go_tx) begin
            link_next.st = LS_TX;
          end else if (link_reg.data_ok || link_reg.mfg_arm) begin
            link_next.st = LS_RX;
          end else begin
            link_next.st = LS_IDLE;
          end
        end
        LS_TX: begin
          link_next.tx_sh  = {link_reg.tx_sh[`EEAF_MFG_ID_W-2:0], 1'b0};
          link_next.bitcnt = link_reg.bitcnt + 3'h1;
          if (link_reg.bitcnt == `EEAF_BIT_LAST) begin
            link_next.st = LS_TACK;
          end
        end
        LS_TACK: begin
          link_next.bitcnt  = 3'h0;
          link_next.tx_left = link_reg.tx_left - 2'h1;
          if (!sda_i && link_next.tx_left != 2'h0) begin
            link_next.st = LS_TX;
          end else begin
            link_next.st      = LS_IDLE;
            link_next.mfg_sel = 1'b0;
          end
        end
      endcase
    end
    if (push) begin
      link_next.req_tgl  = ~link_reg.req_tgl;
      link_next.req_word = {kind, byte_in};
    end
  end

  always_ff @(posedge scl or negedge core_reg.arst_n) begin
    if (!core_reg.arst_n) begin
      link_reg <= LINK_RST;
    end else begin
      link_reg <= link_next;
    end
  end

  // ------------------------------------------------------------
  // data line driver, falling clock edge
  // ------------------------------------------------------------
  always_comb begin
    oe_next = ((link_reg.st == LS_ACK) & link_reg.ack) |
              ((link_reg.st == LS_TX) & ~link_reg.tx_sh[`EEAF_MFG_ID_W-1]);
  end

  always_ff @(negedge scl or negedge core_reg.arst_n) begin
    if (!core_reg.arst_n) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= oe_next;
    end
  end

  // ------------------------------------------------------------
  // system side: reset, handshake receive, write gating
  // ------------------------------------------------------------
  assign new_word = (core_reg.req_s2 != core_reg.ack_tgl);
  assign w_kind   = eeaf_kind_t'(link_reg.req_word[`EEAF_WORD_W-1:`EEAF_BYTE_W]);
  assign w_byte   = link_reg.req_word[`EEAF_BYTE_W-1:0];
  assign buf_in   = {w_kind, wr_ok, w_byte};

  always_comb begin
    wr_ok = 1'b0;
    if (w_kind == WK_DATA && core_reg.idx == 2'h2 && core_reg.wr_dir) begin
      unique case (core_reg.region)
        WK_ARRAY:  wr_ok = ~core_reg.wp_s2;
        WK_SECCFG: begin
          if (core_reg.b1[`EEAF_CFG_SEL_BIT]) begin
            wr_ok = ~cfg_locked;
          end else begin
            wr_ok = ~core_reg.wp_s2 & ~sec_locked & ~core_reg.sn_area;
          end
        end
        WK_DATA, WK_HOST: wr_ok = 1'b0;
      endcase
    end
  end

  always_comb begin
    core_next        = core_reg;
    core_next.arst_n = 1'b1;
    core_next.busy   = wr_busy;
    core_next.wp_s1  = wp;
    core_next.wp_s2  = core_reg.wp_s1;
    core_next.req_s1 = link_reg.req_tgl;
    core_next.req_s2 = core_reg.req_s1;
    if (new_word && buf_rdy) begin
      core_next.ack_tgl = ~core_reg.ack_tgl;
      if (w_kind != WK_DATA) begin
        core_next.region = w_kind;
        core_next.wr_dir = ~w_byte[`EEAF_RW_BIT];
        core_next.idx    = 2'h0;
      end else begin
        unique case (core_reg.idx)
          2'h0: begin
            core_next.b1  = w_byte;
            core_next.idx = 2'h1;
          end
          2'h1: begin
            core_next.page    = {core_reg.b1[`EEAF_B1_PG_MSB:0],
                                 w_byte[`EEAF_BYTE_W-1:`EEAF_B2_PG_LSB]};
            core_next.off     = w_byte[`EEAF_OFF_MSB:0];
            core_next.sn_area = (w_byte[`EEAF_SN_MSB:`EEAF_SN_LSB] == `EEAF_SN_ROW);
            core_next.idx     = 2'h2;
          end
          default: begin
            core_next.off = core_reg.off + `EEAF_OFF_STEP;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      core_reg <= CORE_RST;
      zero_reg <= 1'b0;
    end else begin
      core_reg <= core_next;
      zero_reg <= 1'b0;
    end
  end

  eeaf_buf #(
    .W     (`EEAF_BUF_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_valid  (new_word),
    .in_ready  (buf_rdy),
    .in_data   (buf_in),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (buf_out)
  );

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign sda_o     = zero_reg;
  assign sda_oe    = oe_reg;
  assign standby   = core_reg.arst_n;
  assign out_kind  = buf_out[`EEAF_BUF_W-1:`EEAF_BYTE_W+1];
  assign out_wr_ok = buf_out[`EEAF_BYTE_W];
  assign out_byte  = buf_out[`EEAF_BYTE_W-1:0];
  assign page      = core_reg.page;
  assign page_off  = core_reg.off;

endmodule

// file: eeaf_front_properties.sv
// eeaf_front_properties: port-level assertions for the address front end
`timescale 1ns/1ps
module eeaf_front_properties
  import eeaf_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       scl,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic       hw_addr_pin_bit0,
  input wire logic       hw_addr_pin_bit1,
  input wire logic       hw_addr_pin_bit2,
  input wire logic       wp,
  input wire logic       wr_busy,
  input wire logic       standby,
  input wire logic       out_valid,
  input wire logic       out_ready,
  input wire logic [1:0] out_kind,
  input wire logic       out_wr_ok,
  input wire logic [7:0] out_byte,
  input wire logic [8:0] page,
  input wire logic [5:0] page_off
);
  logic [2:0] pins;
  assign pins = {hw_addr_pin_bit2, hw_addr_pin_bit1, hw_addr_pin_bit0};
  logic       oe_at_rise = 1'b0;
  always @(posedge scl) begin
    if (rst_n) begin
      oe_at_rise <= sda_oe;
    end
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_reset_clears: assert property (@(posedge mclk) $past(!rst_n) |->
    !standby && !sda_oe && !out_valid && page == 9'h000 && page_off == 6'h00)
    else $error("reset left state set");
  a_standby_up: assert property (@(posedge mclk) $rose(rst_n) |=> standby)
    else $error("standby not entered");
  a_sda_pull_only: assert property (@(posedge mclk) sda_o == 1'h0)
    else $error("data line driven high");
  a_oe_scl_low: assert property (@(negedge scl) disable iff (!rst_n)
    sda_oe == oe_at_rise) else $error("data changed with clock high");
  a_busy_no_ack: assert property (@(posedge scl) disable iff (!rst_n)
    wr_busy [*5] |-> !sda_oe) else $error("acknowledge during write cycle");
  a_wp_blocks_write: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(out_valid) && $past(wp, 3) |-> !out_wr_ok) else $error("write allowed under wp");
  a_array_match: assert property (@(posedge mclk) disable iff (!rst_n)
    out_valid && out_kind == WK_ARRAY |-> out_byte[7:1] == {4'hA, pins})
    else $error("array word with wrong address");
  a_seccfg_match: assert property (@(posedge mclk) disable iff (!rst_n)
    out_valid && out_kind == WK_SECCFG |-> out_byte[7:1] == {4'hB, pins})
    else $error("register word with wrong address");
  a_host_code: assert property (@(posedge mclk) disable iff (!rst_n)
    out_valid && out_kind == WK_HOST |-> out_byte[7:3] == 5'h01)
    else $error("host word with wrong code");
  a_out_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    out_valid && !out_ready |=> out_valid && $stable(out_byte) && $stable(out_kind)
    && $stable(out_wr_ok)) else $error("stalled word changed");
  c_ack_seen: cover property (@(posedge scl) sda_oe);
  c_host_word: cover property (@(posedge mclk) out_valid && out_kind == WK_HOST);
  c_stall: cover property (@(posedge mclk) out_valid && !out_ready ##1 out_valid);
endmodule

// file: eeaf_host_model.sv
// eeaf_host_model: bus host that clocks the link, data line has a pull-up
`timescale 1ns/1ps
module eeaf_host_model (
  output logic      scl,
  output logic      sda_h,
  input  wire logic sda_w
);
  initial begin
    scl   = 1'h1;
    sda_h = 1'h1;
  end
  // one 80 ns clock pulse; clock stands still outside frames
  task automatic bit_io(input logic b, output logic s);
    sda_h = b;
    #20 scl = 1'h1;
    #20 s = sda_w;
    #20 scl = 1'h0;
    #20;
  endtask
  task automatic start();
    sda_h = 1'h1;
    #20 scl = 1'h1;
    #20 sda_h = 1'h0;
    #20 scl = 1'h0;
    #20;
  endtask
  task automatic stop();
    sda_h = 1'h0;
    #20 scl = 1'h1;
    #20 sda_h = 1'h1;
    #20;
  endtask
  task automatic send(input logic [7:0] b, input int n, output logic ack);
    logic s;
    for (int i = 7; i > 7 - n; i--) bit_io(b[i], s);
    ack = 1'h0;
    if (n == 8) begin
      bit_io(1'h1, s);
      ack = !s;
    end
  endtask
  task automatic recv(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'h1, d[i]);
    bit_io(last, s);
  endtask
endmodule

// file: testbench.sv
// testbench: random and corner bus traffic through the address front end
`timescale 1ns/1ps
module testbench
  import eeaf_pkg::*;
;
  localparam logic [23:0] MFG = 24'h3C5A96; // arbitrary identification value
  localparam logic [22:0] CASES [8] = '{{4'hA, 8'h15, 8'hFE, 3'h0}, {4'hA, 8'h6B, 8'h40, 3'h4},
    {4'hB, 8'h08, 8'h92, 3'h0}, {4'hB, 8'h08, 8'h92, 3'h4}, {4'hB, 8'h08, 8'hD3, 3'h1},
    {4'hB, 8'h08, 8'h05, 3'h0}, {4'hB, 8'h88, 8'h00, 3'h0}, {4'hB, 8'h88, 8'h00, 3'h2}};
  logic        mclk, rst_n, wp, wr_busy, cfg_locked, sec_locked, out_ready, stall, a, m;
  logic        scl, sda_h, sda_o, sda_oe, standby, out_valid, out_wr_ok, w, c, sl;
  logic [3:0]  ty;
  logic [2:0]  hw, p;
  logic [1:0]  out_kind;
  logic [7:0]  out_byte, d, b1, b2, ab;
  logic [8:0]  page;
  logic [5:0]  page_off;
  logic [10:0] got[$], expq[$];
  logic [23:0] id;
  int          fail_count = 0, num_checks = 0;
  wire         sda_w;
  assign sda_w = sda_h & !(sda_oe & !sda_o);
  eeaf_front #(.MFG_ID(MFG), .BUF_DEPTH(2)) dut (.mclk(mclk), .rst_n(rst_n), .scl(scl),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .hw_addr_pin_bit0(hw[0]),
    .hw_addr_pin_bit1(hw[1]), .hw_addr_pin_bit2(hw[2]), .wp(wp), .wr_busy(wr_busy),
    .cfg_locked(cfg_locked), .sec_locked(sec_locked), .standby(standby),
    .out_valid(out_valid), .out_ready(out_ready), .out_kind(out_kind),
    .out_wr_ok(out_wr_ok), .out_byte(out_byte), .page(page), .page_off(page_off));
  eeaf_host_model host (.scl(scl), .sda_h(sda_h), .sda_w(sda_w));
  initial begin
    mclk = 1'h0;
    forever #25 mclk = !mclk;
  end
  always @(posedge mclk) begin
    if (rst_n === 1'h1 && out_valid === 1'h1 && out_ready === 1'h1)
      got.push_back({out_kind, out_wr_ok, out_byte});
    #2 out_ready = !stall && ($urandom_range(3) != 0);
  end
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  function automatic logic [7:0] dev(input logic [3:0] t, input logic rw);
    return {t, hw, rw};
  endfunction
  function automatic logic exp_ok(input logic [3:0] t, input logic [7:0] x1, input logic [7:0] x2);
    if (t == 4'hA) return !wp;
    if (x1[7]) return !cfg_locked;
    return !wp && !sec_locked && (x2[6:4] != 3'h0);
  endfunction
  task automatic put(input logic [7:0] b, input logic ack_exp, input logic [2:0] kw,
                     input logic push);
    logic ack;
    host.send(b, 8, ack);
    check("ack", ack, ack_exp);
    if (push) expq.push_back({kw, b});
  endtask
  task automatic flush(input logic cmp);
    int i;
    for (i = 0; i < 400 && !(got.size() >= expq.size() && out_valid === 1'h0); i++)
      @(posedge mclk);
    if (i == 400) begin
      check("drain", 24'h1, 24'h0);
      finish_test();
    end
    repeat (8) @(posedge mclk);
    if (cmp) begin
      check("words", 24'(got.size()), 24'(expq.size()));
      foreach (expq[k]) if (k < got.size()) check("word", got[k], expq[k]);
    end
    got.delete();
    expq.delete();
  endtask
  task automatic setin(input logic [2:0] pins, input logic w_, input logic c_, input logic s_);
    @(posedge mclk);
    #2 hw = pins;
    wp = w_;
    cfg_locked = c_;
    sec_locked = s_;
    repeat (4) @(posedge mclk);
  endtask
  task automatic wake();
    repeat (2000) @(posedge mclk);
    host.start();
    host.send(8'hFF, 8, a);
    host.stop();
    check("standby", standby, 24'h1);
  endtask
  initial begin
    {rst_n, wp, wr_busy, cfg_locked, sec_locked, out_ready, stall} = 7'h00;
    hw = 3'h5;
    void'($urandom(32'hB154));
    repeat (8) @(posedge mclk);
    #2 rst_n = 1'h1;
    wake();
    for (int i = 0; i < 12; i++) begin
      setin(3'($urandom), 1'(i % 2), 1'h0, 1'h0);
      ty = (i % 3 == 0) ? 4'($urandom_range(14, 1)) : ((i % 3 == 1) ? 4'hA : 4'hB);
      p = (i % 4 == 3) ? 3'($urandom) : hw;
      ab = {ty, p, 1'(i / 2 % 2)};
      m = (ty == 4'hA || ty == 4'hB) && p == hw;
      host.start();
      put(ab, m, {(ty == 4'hA) ? WK_ARRAY : WK_SECCFG, 1'h0}, m);
      if (m && ab[0]) begin
        host.recv(1'h1, d);
        check("read idle", d, 8'hFF);
      end
      host.stop();
      flush(1'h1);
      host.start();
      put({5'h01, 3'(i)}, 1'h0, {WK_HOST, 1'h0}, 1'h1);
      host.stop();
      flush(1'h1);
    end
    for (int i = 0; i < 8; i++) begin
      {ty, b1, b2, w, c, sl} = CASES[i];
      setin(hw, w, c, sl);
      host.start();
      put(dev(ty, 1'h0), 1'h1, {(ty == 4'hA) ? WK_ARRAY : WK_SECCFG, 1'h0}, 1'h1);
      put(b1, 1'h1, {WK_DATA, 1'h0}, 1'h1);
      put(b2, 1'h1, {WK_DATA, 1'h0}, 1'h1);
      for (int k = 0; k < 3; k++) put(8'($urandom), 1'h1, {WK_DATA, exp_ok(ty, b1, b2)}, 1'h1);
      host.stop();
      flush(1'h1);
      check("page", page, {b1[6:0], b2[7:6]});
      check("offset", page_off, 6'(b2[5:0] + 6'h03));
    end
    stall = 1'h1;
    host.start();
    put(dev(4'hA, 1'h0), 1'h1, {WK_ARRAY, 1'h0}, 1'h1);
    for (int k = 0; k < 6; k++) begin
      d = 8'($urandom);
      host.send(d, 8, a);
      if (a !== 1'h1) break;
      expq.push_back({WK_DATA, (k > 1) && !wp, d});
    end
    check("refused", a, 24'h0);
    host.stop();
    stall = 1'h0;
    flush(1'h1);
    @(posedge mclk);
    #2 wr_busy = 1'h1;
    host.start();
    put(dev(4'hA, 1'h0), 1'h0, 3'h0, 1'h0);
    host.stop();
    #2 wr_busy = 1'h0;
    flush(1'h0);
    host.start();
    host.send(dev(4'hA, 1'h0), 5, a);
    host.start();
    put(dev(4'hA, 1'h1), 1'h1, {WK_ARRAY, 1'h0}, 1'h1);
    host.stop();
    flush(1'h1);
    host.start();
    put(8'hF8, 1'h1, 3'h0, 1'h0);
    put(dev(4'hA, 1'h0), 1'h1, 3'h0, 1'h0);
    host.start();
    put(8'hF9, 1'h1, 3'h0, 1'h0);
    host.recv(1'h0, id[23:16]);
    host.recv(1'h0, id[15:8]);
    host.recv(1'h1, id[7:0]);
    host.stop();
    check("maker id", id, MFG);
    flush(1'h0);
    @(posedge mclk);
    #2 rst_n = 1'h0;
    host.start();
    put(dev(4'hA, 1'h0), 1'h0, 3'h0, 1'h0);
    host.stop();
    check("standby", standby, 24'h0);
    @(posedge mclk);
    #2 rst_n = 1'h1;
    wake();
    flush(1'h0);
    finish_test();
  end
endmodule
bind eeaf_front eeaf_front_properties chk (.mclk(mclk), .rst_n(rst_n), .scl(scl),
  .sda_o(sda_o), .sda_oe(sda_oe), .hw_addr_pin_bit0(hw_addr_pin_bit0),
  .hw_addr_pin_bit1(hw_addr_pin_bit1), .hw_addr_pin_bit2(hw_addr_pin_bit2), .wp(wp),
  .wr_busy(wr_busy), .standby(standby), .out_valid(out_valid), .out_ready(out_ready),
  .out_kind(out_kind), .out_wr_ok(out_wr_ok), .out_byte(out_byte), .page(page),
  .page_off(page_off));
